// *** dinit_pkg.sv ***
// Package of shared constants and types for the DDR2 init pair.
package dinit_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS   = 8;
    localparam int T_POWERUP_US    = 200;
    localparam int T_POWERUP_CYC   =
        (T_POWERUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_CKE_NS        = 400;
    localparam int T_CKE_CYC       =
        (T_CKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_OCD_CLK       = 200;
    localparam int T_MRD_CYC       = 2;
    localparam int T_RP_CYC        = 4;
    localparam int T_RFC_CYC       = 26;
    localparam int N_REFRESH       = 2;

    // ****************************************************************
    // Commands, encoded as {cs_n, ras_n, cas_n, we_n}
    // ****************************************************************
    localparam logic [3:0] CMD_NOP  = 4'h7;
    localparam logic [3:0] CMD_DESL = 4'h8;
    localparam logic [3:0] CMD_PRE  = 4'h2;
    localparam logic [3:0] CMD_REF  = 4'h1;
    localparam logic [3:0] CMD_MRS  = 4'h0;

    // ****************************************************************
    // Mode register fields and register select
    // ****************************************************************
    localparam int MR_BL_LSB = 0;
    localparam int MR_BT_BIT = 3;
    localparam int MR_CL_LSB = 4;
    localparam int MR_TM_BIT = 7;
    localparam int MR_DLL_BIT = 8;
    localparam int MR_WR_LSB = 9;
    localparam int PRE_ALL_BIT = 10;
    localparam logic [2:0] BA_MR   = 3'h0;
    localparam logic [2:0] BA_EMR1 = 3'h1;
    localparam logic [2:0] BA_EMR2 = 3'h2;
    localparam logic [2:0] BA_EMR3 = 3'h3;
    localparam logic [14:0] OCD_DEFAULT = 15'h0380;
    localparam logic [14:0] OCD_MASK    = 15'h0380;

    // ****************************************************************
    // Controller APB register map
    // ****************************************************************
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_MR     = 8'h04;
    localparam logic [7:0] REG_EMR1   = 8'h08;
    localparam logic [7:0] REG_EMR2   = 8'h0C;
    localparam logic [7:0] REG_EMR3   = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [14:0] MR_RESET  = 15'h0432;

    typedef enum logic [2:0] {
        DINIT_BL4 = 3'h2,
        DINIT_BL8 = 3'h3
    } dinit_burst_t;

endpackage : dinit_pkg

// *** dinit_if.sv ***
// Interface carrying the DDR2 command, address and control pins.
`timescale 1ns/1ns
interface dinit_if;
    logic        cke;
    logic        odt;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  ba;
    logic [14:0] addr;

    modport ctrl (output cke, odt, cs_n, ras_n, cas_n, we_n, ba, addr);
    modport dram (input  cke, odt, cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface : dinit_if

// *** dinit_dram.sv ***
// Device end: decodes mode register writes and exposes the settings.
`timescale 1ns/1ns
module dinit_dram
    import dinit_pkg::*;
#(
    parameter int ADDR_W = 15
) (
    input  wire logic        pclk,          // Memory clock.
    input  wire logic        presetn,       // Async reset, active low.
    dinit_if.dram            bus,           // Command pins.
    output logic [14:0]      operating_mode_setting, // Mode register.
    output logic [14:0]      emr1_q,        // Extended register 1.
    output logic [14:0]      emr2_q,        // Extended register 2.
    output logic [14:0]      emr3_q,        // Extended register 3.
    output logic             mr_valid,      // Mode register programmed.
    output logic             dll_reset_p,   // Pulse on DLL reset write.
    output logic [2:0]       burst_size_field, // Burst length code.
    output logic             interleave,    // Burst ordering.
    output logic [2:0]       read_latency,  // Latency in whole cycles.
    output logic             test_select_bit, // Test mode bit.
    output logic [2:0]       wr_recovery,   // Write recovery code.
    output logic             cfg_error      // Unsupported setting seen.
);

    // Only the x8 and x16 address widths can be decoded.
    if (ADDR_W != 15 && ADDR_W != 14) begin : g_bad_width
        $error("ADDR_W must be 14 or 15");
    end

    // ****************************************************************
    // Command decode
    // ****************************************************************
    // Both bank bits pick the register; array state is never touched.
    wire [3:0]  cmd     = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
    wire        is_mrs  = bus.cke && (cmd == CMD_MRS)
                        && !bus.ba[2];                     // [R9] [R14]
    wire [14:0] wval    = (ADDR_W == 15) ? bus.addr
                        : {1'b0, bus.addr[13:0]};                  // [R14]
    wire        hit_mr  = is_mrs && (bus.ba[1:0] == BA_MR[1:0]);   // [R9]
    wire        hit_e1  = is_mrs && (bus.ba[1:0] == BA_EMR1[1:0]);
    wire        hit_e2  = is_mrs && (bus.ba[1:0] == BA_EMR2[1:0]);
    wire        hit_e3  = is_mrs && (bus.ba[1:0] == BA_EMR3[1:0]);
    wire [2:0]  cl_code = wval[MR_CL_LSB +: 3];
    wire [2:0]  bl_code = wval[MR_BL_LSB +: 3];
    wire        bad_set = hit_mr && ((cl_code < 3'h3)
                        || (bl_code != DINIT_BL4
                        && bl_code != DINIT_BL8));         // [R19]

    // Whole-register writes; no field merges with the old value.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            operating_mode_setting <= 15'h0000;
            emr1_q    <= 15'h0000;
            emr2_q    <= 15'h0000;
            emr3_q    <= 15'h0000;
            mr_valid  <= 1'b0;
            cfg_error <= 1'b0;
            dll_reset_p <= 1'b0;
        end else begin
            dll_reset_p <= hit_mr && wval[MR_DLL_BIT];
            if (hit_mr) operating_mode_setting <= wval;  // [R11] [R12]
            if (hit_mr) mr_valid <= 1'b1;                // [R13]
            if (hit_e1) emr1_q <= wval;                  // [R11]
            if (hit_e2) emr2_q <= wval;
            if (hit_e3) emr3_q <= wval;
            if (bad_set) cfg_error <= 1'b1;
        end
    end

    // ****************************************************************
    // Field view of the mode register
    // ****************************************************************
    assign burst_size_field = operating_mode_setting[MR_BL_LSB +: 3]; // [R17]
    assign interleave       = operating_mode_setting[MR_BT_BIT];      // [R21]
    assign read_latency     = operating_mode_setting[MR_CL_LSB +: 3]; // [R17]
    assign test_select_bit  = operating_mode_setting[MR_TM_BIT];      // [R18]
    assign wr_recovery      = operating_mode_setting[MR_WR_LSB +: 3]; // [R18]

endmodule : dinit_dram

// *** dinit_ctrl.sv ***
// Controller end: APB registers and the DDR2 power-up command sequencer.
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
// How it works
// (R1) Hold CKE and ODT low at power-up.
// (R2) Wait 200 us, then NOP and raise CKE.
// (R3) NOP 400 ns, then precharge all.
// (R4) Write extended registers 2 then 3.
// (R5) Enable DLL, then mode write with DLL reset.
// (R6) Precharge all, then two or more refreshes.
// (R7) Mode write with A8 low.
// (R8) OCD default then exit, 200 clocks after reset.
// (R9) Device decodes BA0 and BA1 on mode writes.
// (R10) Program all four mode registers.
// (R11) Each mode write carries the full register.
// (R12) Mode writes leave array contents untouched.
// (R13) Mode register undefined until programmed.
// (R14) Mode write: all strobes and banks low.
// (R15) Mode writes only precharged with CKE high.
// (R16) Wait mode set cycle time after each.
// (R17) Burst length, ordering and latency field layout.
// (R18) Test bit low, A8 DLL reset, write recovery.
// (R19) Only whole-cycle read latencies.
// (R20) Write recovery is rounded-up cycle count.
// (R21) Ordering bit: zero sequential, one interleaved.
// (R22) Only NOP between steps, after spacing.
module dinit_ctrl
    import dinit_pkg::*;
#(
    parameter int POWERUP_CYC = T_POWERUP_CYC,
    parameter int REFRESHES   = N_REFRESH
) (
    input  wire logic        pclk,     // System clock, 125 MHz.
    input  wire logic        presetn,  // Async reset, active low.
    input  wire logic        psel,     // APB select.
    input  wire logic        penable,  // APB access phase.
    input  wire logic        pwrite,   // APB write.
    input  wire logic [7:0]  paddr,    // APB byte address.
    input  wire logic [31:0] pwdata,   // APB write data.
    output logic [31:0]      prdata,   // APB read data.
    output logic             pready,   // APB ready.
    output logic             pslverr,  // APB error.
    dinit_if.ctrl            mem       // DDR2 command pins.
);

    // The refresh count is held in 4 bits, the OCD wait in 8 bits and every other wait in 16 bits.
    if (REFRESHES < 2 || REFRESHES > 15 || POWERUP_CYC < 1
        || POWERUP_CYC > 65536) begin : g_bad_param
        $error("REFRESHES or POWERUP_CYC out of range");
    end

    typedef enum {
        S_IDLE, S_PWR, S_CKE, S_PRE1, S_EMR2, S_EMR3, S_DLLEN, S_DLLRST,
        S_PRE2, S_REF, S_MR, S_OCDWAIT, S_OCDDEF, S_OCDEXIT, S_DONE
    } dinit_state_t;

    // ****************************************************************
    // APB register file
    // ****************************************************************
    logic [14:0]  mr_r, emr1_r, emr2_r, emr3_r;
    logic         start_r;
    dinit_state_t st_r, st_nxt;
    logic         busy, done;

    wire acc      = psel && penable;
    wire wr       = acc && pwrite;
    wire hit_ctrl = paddr == REG_CTRL;
    wire hit_mr   = paddr == REG_MR;
    wire hit_e1   = paddr == REG_EMR1;
    wire hit_e2   = paddr == REG_EMR2;
    wire hit_e3   = paddr == REG_EMR3;
    wire hit_st   = paddr == REG_STATUS;
    wire mapped   = hit_ctrl | hit_mr | hit_e1 | hit_e2 | hit_e3 | hit_st;

    // Zero-wait slave; unmapped addresses answer with an error.
    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;

    // Settings are locked while a sequence runs to keep each write whole.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mr_r    <= MR_RESET;
            emr1_r  <= 15'h0000;
            emr2_r  <= 15'h0000;
            emr3_r  <= 15'h0000;
            start_r <= 1'b0;
        end else begin
            start_r <= wr && hit_ctrl && pwdata[0] && !busy;
            if (wr && !busy && hit_mr) mr_r   <= pwdata[14:0];
            if (wr && !busy && hit_e1) emr1_r <= pwdata[14:0];
            if (wr && !busy && hit_e2) emr2_r <= pwdata[14:0];
            if (wr && !busy && hit_e3) emr3_r <= pwdata[14:0];
        end
    end

    // Read data is registered so it is valid at the access edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= hit_mr ? {17'h0, mr_r}
                    : hit_e1 ? {17'h0, emr1_r}
                    : hit_e2 ? {17'h0, emr2_r}
                    : hit_e3 ? {17'h0, emr3_r}
                    : hit_st ? {30'h0, done, busy}
                    : 32'h0000_0000;
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    logic [15:0] wait_r;
    logic [7:0]  ocd_r;
    logic [3:0]  ref_r;
    logic        cke_r;
    logic [3:0]  cmd_r;
    logic [2:0]  ba_r;
    logic [14:0] addr_r;

    assign busy = (st_r != S_IDLE) && (st_r != S_DONE);
    assign done = st_r == S_DONE;
    wire   wait_done = wait_r == 16'h0000;

    function automatic logic [15:0] cyc(input int n);
        cyc = 16'(n - 1);
    endfunction : cyc

    // Next state waits out each command's spacing before moving on.
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            S_IDLE:    if (start_r) st_nxt = S_PWR;
            S_PWR:     if (wait_done) st_nxt = S_CKE;      // [R2]
            S_CKE:     if (wait_done) st_nxt = S_PRE1;     // [R3]
            S_PRE1:    if (wait_done) st_nxt = S_EMR2;     // [R4]
            S_EMR2:    if (wait_done) st_nxt = S_EMR3;     // [R4]
            S_EMR3:    if (wait_done) st_nxt = S_DLLEN;    // [R5]
            S_DLLEN:   if (wait_done) st_nxt = S_DLLRST;   // [R5]
            S_DLLRST:  if (wait_done) st_nxt = S_PRE2;     // [R6]
            S_PRE2:    if (wait_done) st_nxt = S_REF;
            S_REF:     if (wait_done && ref_r == 4'h1) st_nxt = S_MR; // [R6]
            S_MR:      if (wait_done) st_nxt = S_OCDWAIT;  // [R7]
            S_OCDWAIT: if (ocd_r == 8'h00) st_nxt = S_OCDDEF; // [R8]
            S_OCDDEF:  if (wait_done) st_nxt = S_OCDEXIT;  // [R8]
            S_OCDEXIT: if (wait_done) st_nxt = S_DONE;     // [R10]
            S_DONE:    if (start_r) st_nxt = S_PRE1;
            default:   st_nxt = S_IDLE;
        endcase
    end

    // Command for the first cycle of each state and of each repeated refresh; NOP otherwise.
    logic [3:0]  c_cmd;
    logic [2:0]  c_ba;
    logic [14:0] c_addr;
    logic [15:0] c_wait;
    always_comb begin
        c_cmd  = CMD_NOP;                                    // [R22]
        c_ba   = BA_MR;
        c_addr = 15'h0000;
        c_wait = cyc(T_MRD_CYC);                             // [R16]
        case (st_nxt)
            S_PWR:    c_wait = cyc(POWERUP_CYC);
            S_CKE:    c_wait = cyc(T_CKE_CYC);
            S_PRE1, S_PRE2: begin
                c_cmd = CMD_PRE;
                c_addr[PRE_ALL_BIT] = 1'b1;
                c_wait = cyc(T_RP_CYC);
            end
            S_EMR2:   begin
                c_cmd  = CMD_MRS;
                c_ba   = BA_EMR2;
                c_addr = emr2_r;
            end
            S_EMR3:   begin
                c_cmd  = CMD_MRS;
                c_ba   = BA_EMR3;
                c_addr = emr3_r;
            end
            S_DLLEN:  begin
                c_cmd = CMD_MRS;
                c_ba  = BA_EMR1;
                c_addr = emr1_r & ~OCD_MASK & ~15'h0001;      // DLL on.
            end
            S_DLLRST: begin                                   // [R15] [R14]
                c_cmd = CMD_MRS;
                c_addr = mr_r;
                c_addr[MR_TM_BIT] = 1'b0;                     // [R18]
                c_addr[MR_DLL_BIT] = 1'b1;
            end
            S_REF:    begin
                c_cmd  = CMD_REF;
                c_wait = cyc(T_RFC_CYC);
            end
            S_MR:     begin
                c_cmd = CMD_MRS;
                c_addr = mr_r;                                // [R11] [R20]
                c_addr[MR_TM_BIT] = 1'b0;
                c_addr[MR_DLL_BIT] = 1'b0;                    // [R7]
            end
            S_OCDDEF: begin
                c_cmd = CMD_MRS;
                c_ba  = BA_EMR1;
                c_addr = emr1_r | OCD_DEFAULT;                // [R8]
            end
            S_OCDEXIT: begin
                c_cmd = CMD_MRS;
                c_ba  = BA_EMR1;
                c_addr = emr1_r & ~OCD_MASK;                  // [R8] [R11]
            end
            default:  c_wait = 16'h0000;
        endcase
    end

    wire enter = st_nxt != st_r || (st_r == S_REF && wait_done);

    // CKE stays low until the power-up wait ends; ODT is never driven high.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r   <= S_IDLE;
            wait_r <= 16'h0000;
            ocd_r  <= 8'h00;
            ref_r  <= 4'h0;
            cke_r  <= 1'b0;                                   // [R1]
            cmd_r  <= CMD_NOP;
            ba_r   <= 3'h0;
            addr_r <= 15'h0000;
        end else begin
            st_r <= st_nxt;
            if (st_r == S_PWR && wait_done) cke_r <= 1'b1;    // [R2]
            if (st_nxt == S_DLLRST && st_r != S_DLLRST)
                ocd_r <= 8'(T_OCD_CLK - 1);                   // [R8]
            else if (ocd_r != 8'h00)
                ocd_r <= ocd_r - 8'h01;
            if (st_nxt == S_REF && st_r != S_REF)
                ref_r <= 4'(REFRESHES);
            else if (st_r == S_REF && wait_done)
                ref_r <= ref_r - 4'h1;
            cmd_r  <= enter ? c_cmd : CMD_NOP;
            ba_r   <= enter ? c_ba : 3'h0;
            addr_r <= enter ? c_addr : 15'h0000;
            if (enter) wait_r <= c_wait;
            else if (!wait_done) wait_r <= wait_r - 16'h0001;
        end
    end

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    assign mem.cke   = cke_r;
    assign mem.odt   = 1'b0;                                  // [R1]
    assign mem.cs_n  = cmd_r[3];
    assign mem.ras_n = cmd_r[2];
    assign mem.cas_n = cmd_r[1];
    assign mem.we_n  = cmd_r[0];
    assign mem.ba    = ba_r;
    assign mem.addr  = addr_r;

endmodule : dinit_ctrl

// *** dinit_checker.sv ***
// Assertions on the DDR2 command pins between the two init ends.
`timescale 1ns/1ns
module dinit_checker
    import dinit_pkg::*;
#(
    parameter int POWERUP_CYC = T_POWERUP_CYC
) (
    input wire logic        pclk,    // Clock.
    input wire logic        presetn, // Reset, active low.
    input wire logic        cke,     // Clock enable.
    input wire logic        odt,     // Termination.
    input wire logic        cs_n,    // Select.
    input wire logic        ras_n,   // Row strobe.
    input wire logic        cas_n,   // Column strobe.
    input wire logic        we_n,    // Write enable.
    input wire logic [2:0]  ba,      // Bank select.
    input wire logic [14:0] addr     // Address.
);
    // Command decode shared by the properties.
    wire [3:0] cmd     = {cs_n, ras_n, cas_n, we_n};
    wire       idle    = (cmd == CMD_NOP) || (cmd == CMD_DESL);
    wire       mrs     = (cmd == CMD_MRS);
    wire       dll_rst = mrs && ba == BA_MR && addr[MR_DLL_BIT];
    int        up_cnt_r;
    int        cke_cnt_r;
    int        dll_cnt_r;
    int        ref_cnt_r;

    // Plain int counters; a run is far too short for them to wrap.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_cnt_r  <= 0;
            cke_cnt_r <= 0;
            dll_cnt_r <= 0;
            ref_cnt_r <= 0;
        end else begin
            up_cnt_r  <= up_cnt_r + 1;
            cke_cnt_r <= cke ? cke_cnt_r + 1 : 0;
            dll_cnt_r <= dll_rst ? 0 : dll_cnt_r + 1;
            ref_cnt_r <= (cmd == CMD_PRE) ? 0 : ref_cnt_r + (cmd == CMD_REF);
        end
    end

    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_emr(logic [2:0] sel);
        mrs && ba == sel;
    endsequence
    sequence s_ocd(logic [2:0] v);
        mrs && ba == BA_EMR1 && addr[9:7] == v;
    endsequence
    sequence s_dll_on;
        mrs && ba == BA_EMR1 && !addr[0];
    endsequence

    a_odt_low: assert property (odt == 1'b0)
        else $error("Termination not held low.");
    a_cke_wait: assert property (
        $rose(cke) |-> up_cnt_r >= POWERUP_CYC)
        else $error("Clock enable raised too early.");
    a_cke_held: assert property (cke |=> cke)
        else $error("Clock enable dropped.");
    a_cmd_gap: assert property (
        !idle |-> cke && cke_cnt_r >= T_CKE_CYC)
        else $error("Command too soon after clock enable.");
    a_pre_all: assert property (
        cmd == CMD_PRE |-> addr[PRE_ALL_BIT] ##1 idle[*3])
        else $error("Precharge not all banks or spacing short.");
    a_mrs_space: assert property (mrs |-> !ba[2] ##1 idle)
        else $error("Mode write bank or spacing wrong.");
    a_test_low: assert property (s_emr(BA_MR) |-> !addr[MR_TM_BIT])
        else $error("Test bit set in mode write.");
    a_emr_order: assert property (
        s_emr(BA_EMR2) |=> idle ##[0:8] s_emr(BA_EMR3))
        else $error("Register 3 write missing after register 2.");
    a_dll_order: assert property (
        s_emr(BA_EMR3) ##[1:8] s_dll_on |=> idle ##[0:8] dll_rst)
        else $error("DLL reset write missing after DLL enable.");
    a_pre_again: assert property (
        dll_rst |=> idle ##[0:8] cmd == CMD_PRE)
        else $error("Precharge missing after DLL reset.");
    a_ref_count: assert property (
        s_emr(BA_MR) ##0 !addr[MR_DLL_BIT] |-> ref_cnt_r >= N_REFRESH)
        else $error("Too few refreshes before mode write.");
    a_ocd_delay: assert property (
        s_ocd(3'h7) |-> dll_cnt_r >= T_OCD_CLK - 1)
        else $error("Calibration default too soon.");
    a_ocd_exit: assert property (
        s_ocd(3'h7) |=> idle ##[0:40] s_ocd(3'h0))
        else $error("Calibration exit missing.");
endmodule : dinit_checker

// *** tb_ddr2_init_and_mode_register.sv ***
// Testbench joining both init ends, driving the controller over APB.
`timescale 1ns/1ns
module tb_ddr2_init_and_mode_register
    import dinit_pkg::*;
;
    localparam int PU = 20;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, er;
    logic [14:0] mode_q, emr1_q, emr2_q, emr3_q, cfg [4];
    logic        mr_valid, dll_reset_p, interleave, test_bit, cfg_error;
    logic [2:0]  burst, latency, wr_rec;
    int          miscompares, cmp_count, dll_pulses;
    logic [21:0] trace [$];
    wire  [9:0]  fields = {burst, interleave, latency, wr_rec};
    logic [14:0] rows [3][4] = '{'{15'h0653, 15'h0004, 15'h0080, 15'h0000},
        '{15'h023A, 15'h0040, 15'h0000, 15'h0001},
        '{15'h1A73, 15'h0002, 15'h0008, 15'h0000}};
    logic [6:0]  exp_seq [11] = '{{CMD_PRE, 3'h0}, {CMD_MRS, BA_EMR2},
        {CMD_MRS, BA_EMR3}, {CMD_MRS, BA_EMR1}, {CMD_MRS, BA_MR},
        {CMD_PRE, 3'h0}, {CMD_REF, 3'h0}, {CMD_REF, 3'h0},
        {CMD_MRS, BA_MR}, {CMD_MRS, BA_EMR1}, {CMD_MRS, BA_EMR1}};

    dinit_if ifc ();
    dinit_ctrl #(.POWERUP_CYC(PU), .REFRESHES(N_REFRESH)) u_dinit_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mem(ifc));
    dinit_dram u_dinit_dram (
        .pclk(pclk), .presetn(presetn), .bus(ifc),
        .operating_mode_setting(mode_q), .emr1_q(emr1_q), .emr2_q(emr2_q),
        .emr3_q(emr3_q), .mr_valid(mr_valid), .dll_reset_p(dll_reset_p),
        .burst_size_field(burst), .interleave(interleave),
        .read_latency(latency), .test_select_bit(test_bit),
        .wr_recovery(wr_rec), .cfg_error(cfg_error));
    dinit_checker #(.POWERUP_CYC(PU)) u_dinit_checker (
        .pclk(pclk), .presetn(presetn), .cke(ifc.cke), .odt(ifc.odt),
        .cs_n(ifc.cs_n), .ras_n(ifc.ras_n), .cas_n(ifc.cas_n),
        .we_n(ifc.we_n), .ba(ifc.ba), .addr(ifc.addr));

    // Free-running 125 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Log each command other than NOP; the whole order is judged after a run.
    always @(posedge pclk) begin
        if (presetn && {ifc.cs_n, ifc.ras_n, ifc.cas_n, ifc.we_n} !== CMD_NOP)
            trace.push_back({ifc.cs_n, ifc.ras_n, ifc.cas_n, ifc.we_n,
                             ifc.ba, ifc.addr});
        if (dll_reset_p === 1'b1)
            dll_pulses++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; an idle cycle follows so psel never toggles twice.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n >= 64) begin
            miscompares++;
            close_out();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic prog(input int r);
        cfg = rows[r];
        apb(1'b1, REG_MR, {17'h0, cfg[0]});
        apb(1'b1, REG_EMR1, {17'h0, cfg[1]});
        apb(1'b1, REG_EMR2, {17'h0, cfg[2]});
        apb(1'b1, REG_EMR3, {17'h0, cfg[3]});
    endtask : prog

    // Start a run; with poke set, a busy-time rewrite and restart follow.
    task automatic run_init(input logic poke);
        int n;
        trace.delete();
        dll_pulses = 0;
        apb(1'b1, REG_CTRL, 32'h1);
        if (poke) begin
            apb(1'b1, REG_MR, 32'h0000_0FFF);
            apb(1'b1, REG_CTRL, 32'h1);
        end
        n = 0;
        do begin
            apb(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (rd[1:0] !== 2'b10 && n < 400);
        if (n >= 400) begin
            miscompares++;
            close_out();
        end
    endtask : run_init

    function automatic logic [14:0] exp_a(input int i);
        case (i)
            1: return cfg[2];
            2: return cfg[3];
            3: return cfg[1] & ~OCD_MASK & ~15'h0001;
            4: return (cfg[0] | 15'h0100) & ~15'h0080;
            8: return cfg[0] & ~15'h0100;
            9: return cfg[1] | OCD_DEFAULT;
            10: return cfg[1] & ~OCD_MASK;
            default: return 15'h7FFF;
        endcase
    endfunction : exp_a

    task automatic check_run();
        logic [3:0] c;
        chk(trace.size(), 11);
        for (int i = 0; i < trace.size() && i < 11; i++) begin
            c = trace[i][21:18];
            chk({c, (c == CMD_MRS) ? trace[i][17:15] : 3'h0},
                exp_seq[i]);
            if (exp_a(i) !== 15'h7FFF) begin
                chk(trace[i][14:0], exp_a(i));
            end
        end
        chk(mode_q, cfg[0]);
        chk(emr1_q, cfg[1] & ~OCD_MASK);
        chk({emr2_q, emr3_q}, {cfg[2], cfg[3]});
        chk({mr_valid, test_bit, cfg_error}, 3'b100);
        chk(fields, {cfg[0][2:0], cfg[0][3],
                     cfg[0][6:4], cfg[0][11:9]});
        chk(dll_pulses, 1);
    endtask : check_run

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    // Main sequence: reset, table of configurations, then awkward cases.
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        miscompares = 0;
        cmp_count = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, REG_MR, 32'h0);
        chk(rd, {17'h0, MR_RESET});
        chk(mr_valid, 1'b0);
        apb(1'b0, 8'h18, 32'h0);
        chk({er, rd[30:0]}, 32'h8000_0000);
        for (int r = 0; r < 3; r++) begin
            prog(r);
            run_init(1'b0);
            check_run();
        end
        // A rewrite and restart while busy must both be refused.
        prog(0);
        run_init(1'b1);
        check_run();
        apb(1'b0, REG_MR, 32'h0);
        chk(rd, {17'h0, cfg[0]});
        // A half-cycle or reserved latency code is flagged by the device.
        rows[0][0] = 15'h0623;
        prog(0);
        run_init(1'b0);
        chk(cfg_error, 1'b1);
        // Reset in mid-sequence drops clock enable and the stored modes.
        apb(1'b1, REG_CTRL, 32'h1);
        repeat (20) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({ifc.cke, ifc.odt, mr_valid, cfg_error}, 4'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        prog(1);
        run_init(1'b0);
        check_run();
        close_out();
    end
endmodule : tb_ddr2_init_and_mode_register
